/* File: core/spis_port_flags.sv */
/*
  Port event flag register with its enable register, on an APB slave.
  Assumes event inputs are one-cycle pulses on pclk and the serror bits are
  register levels from the same clock domain; the switch pin is asynchronous.
*/
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module spis_port_flags (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire spis_pkg::spis_event_type events,
  input  wire logic                     serr_phy_ready_toggled,
  input  wire logic                     serr_exchange,
  input  wire logic                     mech_switch_pin,
  input  wire logic                     cold_detect_capable,
  input  wire logic                     mech_switch_supported,
  input  wire logic                     port_switch_present,
  output logic                          port_irq
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  wire       acc_en   = psel && penable;
  wire       hit_flag = (paddr == spis_pkg::EVENT_FLAGS_OFS);
  wire       hit_en   = (paddr == spis_pkg::EVENT_ENABLES_OFS);
  wire       wr_flag  = acc_en && pwrite && hit_flag;
  wire       wr_en    = acc_en && pwrite && hit_en;

  assign pready  = 1'b1;
  assign pslverr = acc_en && !(hit_flag || hit_en);

  // ***************************************************************
  // Switch pin synchroniser
  // ***************************************************************
  logic [2:0] sw_sync_r;
  logic       sw_state_r;
  logic [1:0] fill_r;
  logic       sw_armed_r;
  wire        sw_agree = (sw_sync_r[1] == sw_sync_r[2]);

  // The pipe resets to zero, not to the pin; a pin idling high would
  // look like a toggle, so edges count only once real samples fill it.
  // Limitation: a switch change before the first pin sample after reset is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_r     <= 2'h0;
      sw_armed_r <= 1'b0;
    end else if (!sw_armed_r) begin
      fill_r     <= fill_r + 2'h1;
      sw_armed_r <= (fill_r == spis_pkg::SYNC_FILL);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_sync_r  <= 3'h0;
      sw_state_r <= 1'b0;
    end else begin
      sw_sync_r <= {sw_sync_r[1:0], mech_switch_pin};
      if (!sw_armed_r) begin
        sw_state_r <= sw_sync_r[1];
      end else if (sw_agree) begin
        sw_state_r <= sw_sync_r[2];
      end
    end
  end
  wire sw_toggle = sw_armed_r && sw_agree && (sw_sync_r[2] != sw_state_r);
  wire mech_ok   = mech_switch_supported && port_switch_present;

  // ***************************************************************
  // Event vector
  // ***************************************************************
  logic [31:0] set_vec;
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[spis_pkg::COLD_POS] = events.cold_presence && cold_detect_capable;
    set_vec[spis_pkg::TFE_POS]  = events.d2h_status_err;
    set_vec[spis_pkg::HBF_POS]  = events.host_bus_fatal;
    set_vec[spis_pkg::HBD_POS]  = events.host_bus_data;
    set_vec[spis_pkg::LFE_POS]  = events.link_fatal;
    set_vec[spis_pkg::LNF_POS]  = events.link_nonfatal;
    set_vec[spis_pkg::OVF_POS]  = events.overflow;
    set_vec[spis_pkg::WMT_POS]  = events.fis_no_command && !events.fis_async_notify;
    set_vec[spis_pkg::MECH_POS] = (sw_toggle || events.switch_toggle) && mech_ok;
  end

  // ***************************************************************
  // Sticky flags and enables
  // ***************************************************************
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] enables_r;
  wire  [31:0] clr_vec = wr_flag ? (pwdata & spis_pkg::STICKY_MASK) : 32'h0000_0000;

  assign flags_nxt = ((flags_r & ~clr_vec) | set_vec) & spis_pkg::STICKY_MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= spis_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables_r <= spis_pkg::ENABLES_RESET;
    end else if (wr_en) begin
      enables_r <= pwdata & (spis_pkg::STICKY_MASK | spis_pkg::MIRROR_MASK);
    end
  end

  logic [31:0] status_view;
  always_comb begin
    status_view = flags_r;
    status_view[spis_pkg::PRC_POS]  = serr_phy_ready_toggled;
    status_view[spis_pkg::CONN_POS] = serr_exchange;
  end

  // ***************************************************************
  // Read data and interrupt
  // ***************************************************************
  wire [31:0] rd_mux = hit_flag ? status_view : (hit_en ? enables_r : 32'h0000_0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= |(status_view & enables_r);
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
    set_vec[spis_pkg::TFE_POS] |=> flags_r[spis_pkg::TFE_POS])
    else $error("task file flag lost on set");

  a_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flag && pwdata[spis_pkg::HBF_POS] && !set_vec[spis_pkg::HBF_POS])
      |=> !flags_r[spis_pkg::HBF_POS])
    else $error("host bus fatal not cleared");

  a_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::OVF_POS] && !(wr_flag && pwdata[spis_pkg::OVF_POS]))
      |=> flags_r[spis_pkg::OVF_POS])
    else $error("overflow flag dropped");

  a_notify_excluded: assert property (@(posedge pclk) disable iff (!presetn)
    (events.fis_async_notify && !flags_r[spis_pkg::WMT_POS]) |=> !flags_r[spis_pkg::WMT_POS])
    else $error("notification set multiplier flag");

  a_cold_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!cold_detect_capable && !flags_r[spis_pkg::COLD_POS]) |=> !flags_r[spis_pkg::COLD_POS])
    else $error("cold flag set without capability");

  a_link_fatal_set: assert property (@(posedge pclk) disable iff (!presetn)
    events.link_fatal |=> flags_r[spis_pkg::LFE_POS])
    else $error("link fatal not captured");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::HBD_POS] && enables_r[spis_pkg::HBD_POS]) |=> port_irq)
    else $error("interrupt missing");

  a_mirror_phy: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_flag)
      |=> prdata[spis_pkg::PRC_POS] == $past(serr_phy_ready_toggled))
    else $error("phy ready mirror wrong");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_flag)
      |=> (prdata[21:8] == 14'h0000) && !prdata[25])
    else $error("reserved flag bit set");

  a_cold_set: assert property (@(posedge pclk) disable iff (!presetn)
    (events.cold_presence && cold_detect_capable)
      |=> flags_r[spis_pkg::COLD_POS])
    else $error("cold presence change not captured");

  a_set_wins_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (events.d2h_status_err && wr_flag && pwdata[spis_pkg::TFE_POS])
      |=> flags_r[spis_pkg::TFE_POS])
    else $error("clear beat a same-cycle set");

  a_bus_fatal_set: assert property (@(posedge pclk) disable iff (!presetn)
    events.host_bus_fatal
      |=> flags_r[spis_pkg::HBF_POS])
    else $error("host bus fatal not captured");

  a_bus_data_set: assert property (@(posedge pclk) disable iff (!presetn)
    events.host_bus_data
      |=> flags_r[spis_pkg::HBD_POS])
    else $error("host bus data error not captured");

  a_nonfatal_set: assert property (@(posedge pclk) disable iff (!presetn)
    events.link_nonfatal
      |=> flags_r[spis_pkg::LNF_POS])
    else $error("link nonfatal not captured");

  a_overflow_set: assert property (@(posedge pclk) disable iff (!presetn)
    events.overflow
      |=> flags_r[spis_pkg::OVF_POS])
    else $error("overflow not captured");

  a_wrong_target_set: assert property (@(posedge pclk) disable iff (!presetn)
    (events.fis_no_command && !events.fis_async_notify)
      |=> flags_r[spis_pkg::WMT_POS])
    else $error("multiplier flag not captured");

  a_switch_set: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_toggle && mech_ok)
      |=> flags_r[spis_pkg::MECH_POS])
    else $error("switch change not captured");

  a_switch_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!mech_ok && !flags_r[spis_pkg::MECH_POS])
      |=> !flags_r[spis_pkg::MECH_POS])
    else $error("switch flag set without capability");

  a_mirror_conn: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_flag)
      |=> prdata[spis_pkg::CONN_POS] == $past(serr_exchange))
    else $error("connect mirror wrong");

  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ((status_view & enables_r) == 32'h0000_0000)
      |=> !port_irq)
    else $error("interrupt without enabled flag");

  a_irq_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    (serr_exchange && enables_r[spis_pkg::CONN_POS])
      |=> port_irq)
    else $error("mirror interrupt missing");

  a_disabled_visible: assert property (@(posedge pclk) disable iff (!presetn)
    (events.host_bus_fatal && !enables_r[spis_pkg::HBF_POS])
      |=> flags_r[spis_pkg::HBF_POS])
    else $error("disabled flag not set");

  a_enable_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_en)
      |=> (prdata & ~(spis_pkg::STICKY_MASK | spis_pkg::MIRROR_MASK)) == 32'h0000_0000)
    else $error("reserved enable bit set");

  a_zero_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::LFE_POS] && wr_flag && !pwdata[spis_pkg::LFE_POS])
      |=> flags_r[spis_pkg::LFE_POS])
    else $error("zero write cleared link fatal");

  a_w1c_cold: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flag && pwdata[spis_pkg::COLD_POS] && !set_vec[spis_pkg::COLD_POS])
      |=> !flags_r[spis_pkg::COLD_POS])
    else $error("cold flag not cleared");

  a_w1c_switch: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flag && pwdata[spis_pkg::MECH_POS] && !set_vec[spis_pkg::MECH_POS])
      |=> !flags_r[spis_pkg::MECH_POS])
    else $error("switch flag not cleared");

  a_switch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::MECH_POS] && !(wr_flag && pwdata[spis_pkg::MECH_POS]))
      |=> flags_r[spis_pkg::MECH_POS])
    else $error("switch flag dropped");

  a_target_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::WMT_POS] && !(wr_flag && pwdata[spis_pkg::WMT_POS]))
      |=> flags_r[spis_pkg::WMT_POS])
    else $error("multiplier flag dropped");

  a_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::HBD_POS] && !(wr_flag && pwdata[spis_pkg::HBD_POS]))
      |=> flags_r[spis_pkg::HBD_POS])
    else $error("host bus data flag dropped");

  a_cold_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::COLD_POS] && !(wr_flag && pwdata[spis_pkg::COLD_POS]))
      |=> flags_r[spis_pkg::COLD_POS])
    else $error("cold flag dropped");

  a_tfe_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[spis_pkg::TFE_POS] && !(wr_flag && pwdata[spis_pkg::TFE_POS]))
      |=> flags_r[spis_pkg::TFE_POS])
    else $error("task file flag dropped");

  a_toggle_once: assert property (@(posedge pclk) disable iff (!presetn)
    sw_toggle
      |=> !sw_toggle)
    else $error("switch change counted twice");

endmodule // spis_port_flags

/* File: pkg/spis_pkg.sv */
/*
  Constants, register map and event carrier for the port event flag block.
  Assumes an APB slave at 32-bit data with byte addresses and one clock.
*/
// How it works
// - Cold presence change sets on device arrival or removal.
// - Cold presence flag only meaningful when cold detect capable is one.
// - Task file error sets on received status with error bit zero set.
// - Host bus fatal sets on unrecoverable system bus error.
// - Host bus data error sets on uncorrectable memory data error.
// - Link fatal error sets when a link error stops the transfer.
// - Link nonfatal error sets when a link error lets transfer continue.
// - Overflow sets when device sends more bytes than descriptors allow.
// - Wrong multiplier target sets on a FIS from an idle device.
// - Asynchronous notification FIS never sets wrong multiplier target.
// - Phy ready change is read-only mirror of serror toggle bit.
// - Mech switch change sets when the presence switch opens or closes.
// - Mech switch flag meaningful only with both switch capability bits.
// - Connect change is read-only mirror of serror exchange bit.
// - Writing one clears a sticky flag; writing zero leaves it.
// - Interrupt raised when a flag and its enable are both one.
// - Flags set and visible even when their enable is zero.
package spis_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0]  EVENT_FLAGS_OFS   = 8'h10;
  localparam logic [7:0]  EVENT_ENABLES_OFS = 8'h14;
  localparam logic [31:0] FLAGS_RESET       = 32'h0000_0000;
  localparam logic [31:0] ENABLES_RESET     = 32'h0000_0000;
  // Fill count at the edge that fills the switch pipe with real pin samples and arms it
  localparam logic [1:0]  SYNC_FILL         = 2'h2;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int COLD_POS  = 31;
  localparam int TFE_POS   = 30;
  localparam int HBF_POS   = 29;
  localparam int HBD_POS   = 28;
  localparam int LFE_POS   = 27;
  localparam int LNF_POS   = 26;
  localparam int OVF_POS   = 24;
  localparam int WMT_POS   = 23;
  localparam int PRC_POS   = 22;
  localparam int MECH_POS  = 7;
  localparam int CONN_POS  = 6;

  // Sticky write-one-to-clear bits and read-only mirror bits
  localparam logic [31:0] STICKY_MASK = 32'hFD80_0080;
  localparam logic [31:0] MIRROR_MASK = 32'h0040_0040;

  // ***************************************************************
  // Event carrier, one-cycle pulses from the port logic
  // ***************************************************************
  typedef struct packed {
    logic cold_presence;
    logic d2h_status_err;
    logic host_bus_fatal;
    logic host_bus_data;
    logic link_fatal;
    logic link_nonfatal;
    logic overflow;
    logic fis_no_command;
    logic fis_async_notify;
    logic switch_toggle;
  } spis_event_type;

endpackage

/* File: verif/spis_dev_model.sv */
/*
  Far-side model: device event pulses, serror mirror bits, switch pin.
  Assumes every change is launched just after a rising edge of pclk.
*/
`timescale 1ns/100ps
module spis_dev_model (
  input  wire logic                pclk,
  output spis_pkg::spis_event_type events,
  output logic                     serr_phy_ready_toggled,
  output logic                     serr_exchange,
  output logic                     mech_switch_pin
);
  initial begin
    events = '0;
    serr_phy_ready_toggled = 1'b0;
    serr_exchange = 1'b0;
    mech_switch_pin = 1'b0;
  end
  task automatic pulse(input logic [9:0] v);
    @(posedge pclk);
    events <= spis_pkg::spis_event_type'(v);
    @(posedge pclk);
    events <= '0;
  endtask
  // serror bits take the given values, mirror flags must follow
  task automatic serr(input logic n, input logic x);
    @(posedge pclk);
    serr_phy_ready_toggled <= n;
    serr_exchange <= x;
  endtask
  task automatic flip;
    @(posedge pclk);
    mech_switch_pin <= ~mech_switch_pin;
    repeat (8) @(posedge pclk);
  endtask
endmodule // spis_dev_model

/* File: verif/tb.sv */
/*
  Self-checking bench for the port event flag block over APB.
  Assumes zero-wait APB slave and one-cycle event pulses.
*/
`timescale 1ns/100ps
`define CHK(a,b) begin checked++; if ((a)!==(b)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, port_irq, err;
  logic cold_cap, sw_sup, sw_pres;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  spis_pkg::spis_event_type ev;
  logic n_bit, x_bit, pin;
  int miscompares = 0;
  int checked = 0;
  int pos[8] = '{31, 30, 29, 28, 27, 26, 24, 23};
  spis_dev_model u_spis_dev_model (.pclk(pclk), .events(ev), .serr_phy_ready_toggled(n_bit),
    .serr_exchange(x_bit), .mech_switch_pin(pin));
  spis_port_flags u_spis_port_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(ev), .serr_phy_ready_toggled(n_bit),
    .serr_exchange(x_bit), .mech_switch_pin(pin), .cold_detect_capable(cold_cap),
    .mech_switch_supported(sw_sup), .port_switch_present(sw_pres), .port_irq(port_irq));
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  task automatic wrap_up;
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      wrap_up();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sc_events;
    logic [31:0] e;
    for (int i = 0; i < 8; i++) begin
      e = 32'h1 << pos[i];
      u_spis_dev_model.pulse(10'h001 << (9 - i));
      apb(1'b0, 8'h10, 32'h0);
      `CHK(r, e);
      `CHK(port_irq, 1'b0);
      apb(1'b1, 8'h10, ~e);
      apb(1'b0, 8'h10, 32'h0);
      `CHK(r, e);
      apb(1'b1, 8'h10, e);
      apb(1'b0, 8'h10, 32'h0);
      `CHK(r, 32'h0);
    end
    u_spis_dev_model.pulse(10'h006);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0);
  endtask
  task automatic sc_mirror;
    u_spis_dev_model.serr(1'b1, 1'b1);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0040_0040);
    u_spis_dev_model.serr(1'b0, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0);
  endtask
  task automatic sc_gate;
    cold_cap <= 1'b0;
    u_spis_dev_model.pulse(10'h200);
    u_spis_dev_model.flip();
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0000_0080);
    cold_cap <= 1'b1;
    sw_sup <= 1'b0;
    apb(1'b1, 8'h10, 32'h0000_0080);
    u_spis_dev_model.flip();
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0);
    sw_sup <= 1'b1;
    sw_pres <= 1'b0;
    u_spis_dev_model.pulse(10'h001);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0);
    sw_pres <= 1'b1;
    u_spis_dev_model.pulse(10'h001);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, 32'h0000_0080);
    apb(1'b1, 8'h10, 32'h0000_0080);
  endtask
  task automatic sc_irq;
    apb(1'b1, 8'h14, 32'h4000_0000);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(r, 32'h4000_0000);
    u_spis_dev_model.pulse(10'h100);
    repeat (2) @(posedge pclk);
    `CHK(port_irq, 1'b1);
    apb(1'b1, 8'h10, 32'h4000_0000);
    repeat (2) @(posedge pclk);
    `CHK(port_irq, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    `CHK({err, r}, {1'b1, 32'h0});
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(r, 32'hFDC0_00C0);
    u_spis_dev_model.serr(1'b0, 1'b1);
    repeat (2) @(posedge pclk);
    `CHK(port_irq, 1'b1);
    u_spis_dev_model.serr(1'b0, 1'b0);
    repeat (2) @(posedge pclk);
    `CHK(port_irq, 1'b0);
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    cold_cap = 1; sw_sup = 1; sw_pres = 1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    `CHK(r, spis_pkg::FLAGS_RESET);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(r, spis_pkg::ENABLES_RESET);
    sc_events();
    sc_mirror();
    sc_gate();
    sc_irq();
    wrap_up();
  end
endmodule // tb
